// [logic/jers_map.vh]
`ifndef JERS_MAP_VH
`define JERS_MAP_VH

// ==========================================================
// Instruction register
`define JERS_IR_W 4
`define JERS_IR_CAPTURE 4'h1
`define JERS_IR_CMD 4'h1
`define JERS_IR_DATA 4'h2
`define JERS_IR_ENABLE 4'h3
`define JERS_IR_BYPASS 4'hf
`define JERS_IR_RESET 4'h2

// ==========================================================
// Debug command register
`define JERS_CMD_W 10
`define JERS_CMD_RW_BIT 9
`define JERS_CMD_SEL_HI 6
`define JERS_CMD_SEL_LO 0
`define JERS_CMD_RESET 10'h202

// ==========================================================
// Register-select encodings
`define JERS_SEL_W 7
`define JERS_SEL_ID 7'h02
`define JERS_SEL_GP_BASE 7'h70
`define JERS_SEL_GP_LAST 7'h7b
`define JERS_GP_COUNT 12
`define JERS_SEL_DBG_EN 7'h7e
`define JERS_SEL_TRACE 7'h7c
`define JERS_SEL_TRACE_CTRL 7'h6f
`define JERS_SEL_SCAN_LATCH 7'h7d

// ==========================================================
// Device identification register
`define JERS_ID_OFFSET 7'h02
`define JERS_ID_W 32
`define JERS_ID_VER_HI 31
`define JERS_ID_VER_LO 28
`define JERS_ID_CENTER_HI 27
`define JERS_ID_CENTER_LO 22
`define JERS_ID_SEQ_HI 21
`define JERS_ID_SEQ_LO 12
`define JERS_ID_MFR_HI 11
`define JERS_ID_MFR_LO 1
`define JERS_ID_MARK_BIT 0
`define JERS_ID_MARK 1'b1

// ==========================================================
// Timing
`define JERS_KEY_DELAY 2

`endif

// [logic/jers_sync.v]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Two-stage synchroniser
module jers_sync #(
  parameter W = 1
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule // jers_sync

`default_nettype wire

// [logic/jers_ext_regsel.v]
`timescale 1ns/1ns
`default_nettype none

`include "jers_map.vh"

module jers_ext_regsel #(
  // Arbitrary neutral identity values
  parameter [5:0] ID_CENTER = 6'h15,
  parameter [10:0] ID_MFR = 11'h2a5,
  parameter [7:0] ID_SEQ_LOW = 8'h5a
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  input wire i_trst_n,
  input wire i_key_in,
  input wire i_ext_serial_data,
  input wire i_debug_enable_input,
  input wire [3:0] i_ident_version_strap,
  input wire [1:0] i_ident_sequence_strap,
  output reg o_tdo,
  output reg o_tdo_en,
  output reg o_ext_reg_update_strobe,
  output reg [`JERS_GP_COUNT-1:0] o_general_purpose_select,
  output reg o_dbg_enable_select,
  output reg o_trace_select,
  output reg o_trace_ctrl_select,
  output reg o_scan_latch_select,
  output reg o_shift_data_state_flag,
  output reg o_capture_data_state_flag
);

  // ========================================================
  // Controller states
  localparam [3:0] ST_TLR = 4'h0;
  localparam [3:0] ST_RTI = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UP_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'ha;
  localparam [3:0] ST_SH_IR = 4'hb;
  localparam [3:0] ST_EX1_IR = 4'hc;
  localparam [3:0] ST_PA_IR = 4'hd;
  localparam [3:0] ST_EX2_IR = 4'he;
  localparam [3:0] ST_UP_IR = 4'hf;

  localparam [1:0] PATH_BYPASS = 2'h0;
  localparam [1:0] PATH_CMD = 2'h1;
  localparam [1:0] PATH_ID = 2'h2;
  localparam [1:0] PATH_EXT = 2'h3;

  // ========================================================
  // Functions
  function [3:0] tap_next;
    input [3:0] st;
    input tms;
    begin
      case (st)
        ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
        ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: tap_next = tms ? ST_UP_DR : ST_PA_DR;
        ST_PA_DR: tap_next = tms ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: tap_next = tms ? ST_UP_DR : ST_SH_DR;
        ST_UP_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: tap_next = tms ? ST_UP_IR : ST_PA_IR;
        ST_PA_IR: tap_next = tms ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: tap_next = tms ? ST_UP_IR : ST_SH_IR;
        ST_UP_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
        default: tap_next = ST_TLR;
      endcase
    end
  endfunction

  // True for every code that names an outside register
  function is_ext;
    input [`JERS_SEL_W-1:0] sel;
    begin
      is_ext = ((sel >= `JERS_SEL_GP_BASE) && (sel <= `JERS_SEL_GP_LAST)) ||
               (sel == `JERS_SEL_DBG_EN) || (sel == `JERS_SEL_TRACE) ||
               (sel == `JERS_SEL_TRACE_CTRL) || (sel == `JERS_SEL_SCAN_LATCH);
    end
  endfunction

  // ========================================================
  // Pin synchronisers
  wire [12:0] pins_s;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire trst_n_s;
  wire key_s;
  wire ser_s;
  wire dbgen_s;
  wire [3:0] ver_s;
  wire [1:0] seq_s;

  jers_sync #(
    .W(13)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_tck, i_tms, i_tdi, i_trst_n, i_key_in, i_ext_serial_data,
              i_debug_enable_input, i_ident_version_strap, i_ident_sequence_strap}),
    .o_sync(pins_s)
  );

  assign {tck_s, tms_s, tdi_s, trst_n_s, key_s, ser_s, dbgen_s, ver_s, seq_s} = pins_s;

  // ========================================================
  // State
  reg tck_d_ff;
  reg [3:0] state_ff;
  reg [`JERS_IR_W-1:0] ir_ff;
  reg [`JERS_IR_W-1:0] ir_sr_ff;
  reg [`JERS_CMD_W-1:0] cmd_ff;
  reg [`JERS_ID_W-1:0] dr_sr_ff;
  reg key_d1_ff;
  reg key_d2_ff;

  wire tck_rise = tck_s & ~tck_d_ff;
  wire [`JERS_SEL_W-1:0] regsel = cmd_ff[`JERS_CMD_SEL_HI:`JERS_CMD_SEL_LO];
  wire key_mode = (ir_ff == `JERS_IR_ENABLE) && !dbgen_s;
  wire [3:0] state_nxt = tap_next(state_ff, tms_s);

  // Identification word
  wire [`JERS_ID_W-1:0] id_word = {ver_s, ID_CENTER, seq_s, ID_SEQ_LOW, ID_MFR, `JERS_ID_MARK};

  reg [1:0] dr_path;
  always @* begin
    if (ir_ff == `JERS_IR_CMD) begin
      dr_path = PATH_CMD;
    end else if ((ir_ff == `JERS_IR_DATA) && (regsel == `JERS_SEL_ID)) begin
      dr_path = PATH_ID;
    end else if ((ir_ff == `JERS_IR_DATA) && is_ext(regsel)) begin
      dr_path = PATH_EXT;
    end else begin
      dr_path = PATH_BYPASS;
    end
  end

  // ========================================================
  // Shift register next values
  reg [`JERS_ID_W-1:0] nxt_dr_sr_ff;
  reg [`JERS_IR_W-1:0] nxt_ir_sr_ff;
  reg nxt_tdo;

  always @* begin
    nxt_dr_sr_ff = dr_sr_ff;
    nxt_ir_sr_ff = ir_sr_ff;
    if (state_ff == ST_CAP_DR) begin
      case (dr_path)
        PATH_CMD: nxt_dr_sr_ff = {{(`JERS_ID_W-`JERS_CMD_W){1'b0}}, cmd_ff};
        PATH_ID: nxt_dr_sr_ff = id_word;
        default: nxt_dr_sr_ff = {`JERS_ID_W{1'b0}};
      endcase
    end else if (state_ff == ST_SH_DR) begin
      // Least significant bit leaves first
      case (dr_path)
        PATH_CMD: nxt_dr_sr_ff = {{(`JERS_ID_W-`JERS_CMD_W){1'b0}}, tdi_s, dr_sr_ff[`JERS_CMD_W-1:1]};
        PATH_ID: nxt_dr_sr_ff = {tdi_s, dr_sr_ff[`JERS_ID_W-1:1]};
        default: nxt_dr_sr_ff = {{(`JERS_ID_W-1){1'b0}}, tdi_s};
      endcase
    end
    if (state_ff == ST_CAP_IR) begin
      nxt_ir_sr_ff = `JERS_IR_CAPTURE;
    end else if (state_ff == ST_SH_IR) begin
      nxt_ir_sr_ff = {tdi_s, ir_sr_ff[`JERS_IR_W-1:1]};
    end
    nxt_tdo = o_tdo;
    if (state_nxt == ST_SH_DR) begin
      if (dr_path == PATH_EXT) begin
        nxt_tdo = ser_s;
      end else begin
        nxt_tdo = nxt_dr_sr_ff[0];
      end
    end else if (state_nxt == ST_SH_IR) begin
      if (key_mode) begin
        nxt_tdo = key_d2_ff;
      end else begin
        nxt_tdo = nxt_ir_sr_ff[0];
      end
    end
  end

  // ========================================================
  // Test-clock edge processing
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      tck_d_ff <= 1'b0;
      state_ff <= ST_TLR;
      ir_ff <= `JERS_IR_RESET;
      ir_sr_ff <= {`JERS_IR_W{1'b0}};
      cmd_ff <= `JERS_CMD_RESET;
      dr_sr_ff <= {`JERS_ID_W{1'b0}};
      key_d1_ff <= 1'b0;
      key_d2_ff <= 1'b0;
      o_tdo <= 1'b0;
    end else begin
      tck_d_ff <= tck_s;
      if (!trst_n_s) begin
        state_ff <= ST_TLR;
        ir_ff <= `JERS_IR_RESET;
        cmd_ff <= `JERS_CMD_RESET;
      end else if (tck_rise) begin
        state_ff <= state_nxt;
        dr_sr_ff <= nxt_dr_sr_ff;
        ir_sr_ff <= nxt_ir_sr_ff;
        o_tdo <= nxt_tdo;
        if ((state_ff == ST_SH_IR) && key_mode) begin
          key_d1_ff <= key_s;
          key_d2_ff <= key_d1_ff;
        end
        case (state_ff)
          ST_TLR: begin
            ir_ff <= `JERS_IR_RESET;
            cmd_ff <= `JERS_CMD_RESET;
          end
          ST_UP_IR: begin
            ir_ff <= ir_sr_ff;
          end
          ST_UP_DR: begin
            if (dr_path == PATH_CMD) begin
              cmd_ff <= dr_sr_ff[`JERS_CMD_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ========================================================
  // Strobes, flags and selects
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_tdo_en <= 1'b0;
      o_ext_reg_update_strobe <= 1'b0;
      o_shift_data_state_flag <= 1'b0;
      o_capture_data_state_flag <= 1'b0;
      o_dbg_enable_select <= 1'b0;
      o_trace_select <= 1'b0;
      o_trace_ctrl_select <= 1'b0;
      o_scan_latch_select <= 1'b0;
    end else begin
      o_tdo_en <= (state_ff == ST_SH_DR) || (state_ff == ST_SH_IR);
      o_ext_reg_update_strobe <= (state_ff == ST_UP_DR) && (ir_ff == `JERS_IR_DATA) &&
                                 !cmd_ff[`JERS_CMD_RW_BIT];
      o_shift_data_state_flag <= (state_ff == ST_SH_DR);
      o_capture_data_state_flag <= (state_ff == ST_CAP_DR);
      o_dbg_enable_select <= (regsel == `JERS_SEL_DBG_EN);
      o_trace_select <= (regsel == `JERS_SEL_TRACE);
      o_trace_ctrl_select <= (regsel == `JERS_SEL_TRACE_CTRL);
      o_scan_latch_select <= (regsel == `JERS_SEL_SCAN_LATCH);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `JERS_GP_COUNT; gi = gi + 1) begin : g_gp_sel
      localparam [31:0] GP_IDX = gi;
      always @(posedge i_sys_clk) begin
        if (i_rst) begin
          o_general_purpose_select[gi] <= 1'b0;
        end else begin
          o_general_purpose_select[gi] <= (regsel == (`JERS_SEL_GP_BASE + GP_IDX[6:0]));
        end
      end
    end
  endgenerate

endmodule // jers_ext_regsel

`default_nettype wire

// [sim/jers_ext_regsel_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker
module jers_chk (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_tck,
  input wire i_trst_n,
  input wire o_tdo,
  input wire o_tdo_en,
  input wire o_ext_reg_update_strobe,
  input wire [11:0] o_general_purpose_select,
  input wire o_dbg_enable_select,
  input wire o_trace_select,
  input wire o_trace_ctrl_select,
  input wire o_scan_latch_select,
  input wire o_shift_data_state_flag
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire stb = o_ext_reg_update_strobe;
  wire sh = o_shift_data_state_flag;
  wire [15:0] sel = {o_scan_latch_select, o_trace_ctrl_select, o_trace_select, o_dbg_enable_select,
    o_general_purpose_select};
  AST_ONE_SEL: assert property ($onehot0(sel)) else $error("two selects");
  AST_SEL_HOLD: assert property ($changed(sel) |-> !o_tdo_en && !$past(o_tdo_en))
    else $error("select moved in shift");
  AST_STB_STATE: assert property (stb |-> !o_tdo_en) else $error("strobe in shift");
  AST_STB_LEN: assert property ($rose(stb) |-> stb[*8] ##1 !stb) else $error("strobe length");
  AST_STB_AFTER: assert property ($rose(stb) |-> $past(sh, 12)) else $error("strobe no shift");
  AST_EN_SHIFT: assert property (sh |-> o_tdo_en) else $error("shift no enable");
  AST_TDO_EDGE: assert property ($changed(o_tdo) |-> $past(i_tck, 2)) else $error("tdo off edge");
  AST_TRST: assert property ($fell(i_trst_n) |-> ##[1:8] (!o_tdo_en && sel == 16'h0))
    else $error("test reset ignored");
  CV_STB: cover property ($rose(stb));
  CV_GP: cover property (o_general_purpose_select[11]);
  CV_IR: cover property (o_tdo_en && !sh);
endmodule // jers_chk
bind jers_ext_regsel jers_chk u_jers_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tck(i_tck),
  .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_en(o_tdo_en), .o_ext_reg_update_strobe(o_ext_reg_update_strobe),
  .o_general_purpose_select(o_general_purpose_select), .o_dbg_enable_select(o_dbg_enable_select),
  .o_trace_select(o_trace_select), .o_trace_ctrl_select(o_trace_ctrl_select),
  .o_scan_latch_select(o_scan_latch_select), .o_shift_data_state_flag(o_shift_data_state_flag));
`default_nettype wire

// [sim/jers_ext_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// External registers and key source
module jers_ext_model (
  input wire i_tck,
  input wire i_tdi,
  input wire i_upd,
  input wire [13:0] i_sel,
  input wire i_cap,
  input wire i_shift,
  output logic o_ser,
  output logic o_key
);
  logic [7:0] rg [0:13] = '{default: 8'h00};
  logic [7:0] sh = 8'h00;
  logic [15:0] key = 16'hc59a;
  wire any = |i_sel;
  int idx;
  always_comb begin
    idx = 0;
    for (int n = 0; n < 14; n++)
      if (i_sel[n]) idx = n;
  end
  // Unselected return line shows the inverse of the last bit
  assign o_ser = any ? sh[0] : ~sh[0];
  assign o_key = key[0];
  always @(posedge i_tck) begin
    if (i_cap) sh <= rg[idx];
    else if (i_shift) sh <= {i_tdi, sh[7:1]};
    if (i_upd && any) rg[idx] <= sh;
  end
  always @(negedge i_tck) key <= {key[0], key[15:1]};
endmodule // jers_ext_model
`default_nettype wire

// [sim/tb_jers_ext_regsel.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
// ==========
// Testbench
module tb_jers_ext_regsel;
  localparam [5:0] CTR = 6'h2b; // Arbitrary identity value
  localparam [10:0] MFR = 11'h155; // Arbitrary identity value
  localparam [7:0] SQL = 8'hc3; // Arbitrary identity value
  logic clk = 0, rst = 1, tck = 0, tms = 1, tdi = 0, trst_n = 1, dbg_en = 0, stb_s;
  logic [3:0] ver = 4'h9;
  logic [1:0] seq = 2'h2;
  logic [31:0] got = 0, res;
  logic key_q [$];
  int err_total = 0, checked = 0;
  wire key, ser, tdo, tdo_en, stb, dbg, trc, tctl, scn, sf, cf;
  wire [11:0] gp;
  jers_ext_regsel #(.ID_CENTER(CTR), .ID_MFR(MFR), .ID_SEQ_LOW(SQL)) u_jers_ext_regsel (
    .i_sys_clk(clk), .i_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n),
    .i_key_in(key), .i_ext_serial_data(ser), .i_debug_enable_input(dbg_en),
    .i_ident_version_strap(ver), .i_ident_sequence_strap(seq), .o_tdo(tdo), .o_tdo_en(tdo_en),
    .o_ext_reg_update_strobe(stb), .o_general_purpose_select(gp), .o_dbg_enable_select(dbg),
    .o_trace_select(trc), .o_trace_ctrl_select(tctl), .o_scan_latch_select(scn),
    .o_shift_data_state_flag(sf), .o_capture_data_state_flag(cf));
  jers_ext_model u_jers_ext_model (.i_tck(tck), .i_tdi(tdi), .i_upd(stb), .i_sel({scn, dbg, gp}),
    .i_cap(cf), .i_shift(sf), .o_ser(ser), .o_key(key));
  initial forever #25 clk = ~clk;
  // One test clock period; tdo is taken just before the rising edge
  task automatic tick(input logic m, input logic d);
    tck = 0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    got = {tdo, got[31:1]};
    stb_s = stb;
    key_q.push_back(key);
    tck = 1;
    repeat (4) @(negedge clk);
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] d);
    tick(1, 0);
    if (ir) tick(1, 0);
    tick(0, 0);
    `CHK(cf, ~ir)
    tick(0, 0);
    `CHK({tdo_en, sf, cf}, {1'b1, ~ir, 1'b0})
    key_q = {};
    for (int i = 0; i < n; i++) tick(i == n - 1, d[i]);
    res = got >> (32 - n);
    tick(1, 0);
    tick(0, 0);
  endtask
  task automatic wr_cmd(input logic rw, input logic [6:0] s);
    scan(1, 4, 32'h1);
    scan(0, 10, {22'h0, rw, 2'b00, s});
    scan(1, 4, 32'h2);
  endtask
  task automatic t_id();
    for (int k = 0; k < 2; k++) begin
      ver = k ? 4'h6 : 4'h9;
      seq = k ? 2'h1 : 2'h2;
      trst_n = 0;
      repeat (4) @(negedge clk);
      trst_n = 1;
      tick(0, 0);
      scan(0, 32, 0);
      `CHK(res, {ver, CTR, seq, SQL, MFR, 1'b1})
      `CHK(res[0], 1'b1)
    end
  endtask
  task automatic t_sel();
    logic [6:0] sp [4] = '{7'h7e, 7'h7c, 7'h6f, 7'h7d};
    for (int i = 0; i < 17; i++) begin
      wr_cmd(0, i < 12 ? 7'h70 + 7'(i) : i < 16 ? sp[i - 12] : 7'h02);
      `CHK({scn, tctl, trc, dbg, gp}, 16'(32'h1 << i))
    end
  endtask
  task automatic t_ext();
    logic [6:0] cd [2] = '{7'h75, 7'h7e};
    for (int k = 0; k < 2; k++) begin
      wr_cmd(0, cd[k]);
      scan(0, 8, 32'ha6 ^ k);
      `CHK(stb_s, 1'b1)
      scan(0, 8, 32'h3c);
      `CHK(res[7:0], 8'ha6 ^ 8'(k))
      wr_cmd(1, cd[k]);
      scan(0, 8, 32'h55);
      `CHK(stb_s, 1'b0)
      `CHK(res[7:0], 8'h3c)
    end
    wr_cmd(1, 7'h02);
    scan(0, 32, 0);
    `CHK(res, {ver, CTR, seq, SQL, MFR, 1'b1})
  endtask
  task automatic t_key();
    scan(1, 4, 32'h3);
    scan(1, 12, 32'h333);
    for (int i = 3; i < 12; i++) `CHK(res[i], key_q[i - 3])
    dbg_en = 1;
    scan(1, 12, 32'h333);
    `CHK(res[11:0], 12'h331)
    dbg_en = 0;
    scan(1, 4, 32'h2);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    `CHK({tdo, tdo_en, stb, gp, dbg, trc, tctl, scn, sf, cf}, 21'h0)
    rst = 0;
    repeat (4) @(negedge clk);
    t_id();
    t_sel();
    t_ext();
    t_key();
    finish_test();
  end
endmodule // tb_jers_ext_regsel
`default_nettype wire
